/* design/fcs_top.sv */
`timescale 1ns/100ps
`include "fcs_consts.svh"
module fcs_top #(
    parameter logic [11:0] POR_FAST_CYCLES = `FCS_POR_FAST_CYC,
    parameter logic [11:0] POR_STD_CYCLES = `FCS_POR_STD_CYC,
    parameter logic [7:0] INIT_CYCLES = `FCS_INIT_CYC,
    parameter logic [7:0] CONFIG_CLOCK_HALF = `FCS_CONFIG_CLOCK_HALF,
    parameter logic [7:0] READ_OPCODE = `FCS_READ_OPCODE,
    parameter bit HAS_USER_CLK = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] scheme_select_pins,
    input wire logic config_request_n,
    input wire logic chip_enable_in_n,
    input wire logic jtag_config_req,
    input wire logic config_status_line_n_i,
    output logic config_status_line_n_o,
    output logic config_status_line_n_oe,
    input wire logic load_complete_line_i,
    output logic load_complete_line_o,
    output logic load_complete_line_oe,
    input wire logic config_clock_i,
    output logic config_clock_o,
    output logic config_clock_oe,
    input wire logic user_clock_source,
    input wire logic [7:0] config_data_i,
    input wire logic serial_addr_data_out_i,
    output logic serial_addr_data_out_o,
    output logic serial_addr_data_out_oe,
    output logic serial_flash_select_n,
    output logic chain_enable_out_n,
    output logic user_pin_oe,
    output logic weak_pullup_en,
    output logic user_mode
);
    ////////////////////////////////////////////////////////////////////////
    // Pin resynchronisation
    logic [18:0] pins_q;
    logic [18:0] pins_rise;
    logic s_jtag, s_ce_n, s_req, s_stat, s_done, s_ado;
    logic done_rise, config_clock_rise, usr_rise;
    logic [7:0] s_data;
    logic [2:0] s_strap;

    fcs_sync #(.W(19)) u_sync (
        .clk(core_clk),
        .rst(rst),
        .d({scheme_select_pins, serial_addr_data_out_i, config_data_i,
            user_clock_source, config_clock_i, load_complete_line_i,
            config_status_line_n_i, config_request_n, chip_enable_in_n,
            jtag_config_req}),
        .q(pins_q),
        .rise(pins_rise)
    );

    assign s_jtag = pins_q[0];
    assign s_ce_n = pins_q[1];
    assign s_req = pins_q[2];
    assign s_stat = pins_q[3];
    assign s_done = pins_q[4];
    assign done_rise = pins_rise[4];
    assign config_clock_rise = pins_rise[5];
    assign usr_rise = pins_rise[6];
    assign s_data = pins_q[14:7];
    assign s_ado = pins_q[15];
    assign s_strap = pins_q[18:16];

    // Open-drain lines only ever pull low
    assign config_status_line_n_o = 1'b0;
    assign load_complete_line_o = 1'b0;

    function automatic logic [31:0] fcs_expand(input logic [7:0] b,
                                               input logic cmp);
        // A run byte stands for (low bits + 1) zero bytes
        if (cmp && b[`FCS_CMP_RUN_BIT]) begin
            return {21'h0, ({1'b0, b[6:0]} + 8'h01), 3'h0};
        end
        return 32'h0000_0008;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    fcs_pkg::fcs_ctrl_t ctrl_q, ctrl_d;
    logic [31:0] len_q, len_d, rdata_q, rdata_d, rd_mux;
    logic wait_q, wait_d;
    fcs_pkg::fcs_state_t state_q, state_d;
    fcs_pkg::fcs_mode_t mode_q, mode_d;
    logic [31:0] bits_q, bits_d;
    logic [7:0] chk_q, chk_d;
    logic user_mode_q, user_mode_d;

    always_comb begin
        unique case (avs_address)
            `FCS_OFF_CTRL: rd_mux = {30'h0, ctrl_q};
            `FCS_OFF_LEN: rd_mux = len_q;
            `FCS_OFF_STAT: rd_mux = {24'h0, user_mode_q, mode_q.por_slow,
                                     mode_q.scheme, 1'b0, state_q};
            `FCS_OFF_COUNT: rd_mux = bits_q;
            `FCS_OFF_CHK: rd_mux = {24'h0, chk_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        ctrl_d = ctrl_q;
        len_d = len_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        // One wait cycle, then a single cycle answer
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            if (avs_read) begin
                rdata_d = rd_mux;
            end
        end
        if (avs_write && !wait_q) begin
            if (avs_address == `FCS_OFF_CTRL) begin
                ctrl_d.compress = avs_writedata[`FCS_CTRL_COMPRESS];
                ctrl_d.user_clk = avs_writedata[`FCS_CTRL_USER_CLK];
            end
            if (avs_address == `FCS_OFF_LEN) begin
                len_d = avs_writedata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `FCS_CTRL_RESET;
            len_q <= `FCS_LEN_RESET;
            rdata_q <= 32'h0;
            wait_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            len_q <= len_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration sequencer
    logic [11:0] por_cnt_q, por_cnt_d, por_limit;
    logic [7:0] div_q, div_d, init_q, init_d, sr_q, sr_d, op_q, op_d, word;
    logic [3:0] op_cnt_q, op_cnt_d;
    logic [2:0] nib_q, nib_d;
    logic clk_q, clk_d, tick, src, master, par, byte_rdy, op_busy;
    logic stat_oe_q, stat_oe_d, done_oe_q, done_oe_d, cclk_oe_q, cclk_oe_d;
    logic ado_q, ado_d, ado_oe_q, ado_oe_d, fsel_n_q, fsel_n_d;
    logic chain_n_q, chain_n_d, user_oe_q, user_oe_d, pu_q, pu_d;

    assign master = mode_q.scheme == fcs_pkg::SCH_SELF_DRIVEN_SERIAL ||
                    mode_q.scheme == fcs_pkg::SCH_PARALLEL_FLASH_MASTER;
    assign par = mode_q.scheme == fcs_pkg::SCH_PARALLEL_FLASH_MASTER ||
                 mode_q.scheme == fcs_pkg::SCH_SLAVE_PARALLEL_FAST;
    assign por_limit = mode_q.por_slow ? POR_STD_CYCLES : POR_FAST_CYCLES;
    assign op_busy = mode_q.scheme == fcs_pkg::SCH_SELF_DRIVEN_SERIAL &&
                     op_cnt_q != `FCS_OPCODE_BITS;
    // Address pin doubles as data bit 1 in parallel schemes
    assign word = par ? {s_data[7:2], s_ado, s_data[0]}
                      : {sr_q[6:0], s_data[0]};
    assign byte_rdy = par || nib_q == 3'h7;

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        por_cnt_d = por_cnt_q;
        div_d = 8'h0;
        clk_d = 1'b0;
        init_d = init_q;
        sr_d = sr_q;
        nib_d = nib_q;
        op_d = op_q;
        op_cnt_d = op_cnt_q;
        ado_d = ado_q;
        bits_d = bits_q;
        chk_d = chk_q;
        tick = 1'b0;
        src = 1'b1;
        if (state_q == fcs_pkg::ST_CONFIG) begin
            if (master) begin
                // Core clock cycles, or user clock rising edges, divided down
                if (HAS_USER_CLK && ctrl_q.user_clk) begin
                    src = usr_rise;
                end
                div_d = div_q;
                clk_d = clk_q;
                if (src) begin
                    if (div_q == CONFIG_CLOCK_HALF - 8'h01) begin
                        div_d = 8'h0;
                        clk_d = ~clk_q;
                        tick = ~clk_q;
                    end else begin
                        div_d = div_q + 8'h01;
                    end
                end
            end else begin
                tick = config_clock_rise;
            end
        end
        unique case (state_q)
            fcs_pkg::ST_POR: begin
                // Straps caught every cycle until power-on reset ends
                mode_d = fcs_pkg::fcs_mode_t'(s_strap);
                por_cnt_d = por_cnt_q + 12'h001;
                if (por_cnt_q == por_limit) begin
                    state_d = fcs_pkg::ST_RESET;
                end
            end
            fcs_pkg::ST_RESET: begin
                if (s_req) begin
                    state_d = fcs_pkg::ST_RELEASE;
                end
            end
            fcs_pkg::ST_RELEASE: begin
                op_d = READ_OPCODE;
                op_cnt_d = 4'h0;
                nib_d = 3'h0;
                bits_d = 32'h0;
                chk_d = 8'h0;
                if (s_stat && !s_ce_n) begin
                    state_d = fcs_pkg::ST_CONFIG;
                end
            end
            fcs_pkg::ST_CONFIG: begin
                if (tick && op_busy) begin
                    ado_d = op_q[7];
                    op_d = {op_q[6:0], 1'b0};
                    op_cnt_d = op_cnt_q + 4'h1;
                end else if (tick) begin
                    sr_d = word;
                    nib_d = nib_q + 3'h1;
                    if (byte_rdy) begin
                        bits_d = bits_q + fcs_expand(word, ctrl_q.compress);
                        chk_d = chk_q ^ word;
                    end
                end
                if (bits_q >= len_q) begin
                    state_d = fcs_pkg::ST_DONE_WAIT;
                end
            end
            fcs_pkg::ST_DONE_WAIT: begin
                init_d = 8'h0;
                if (done_rise) begin
                    state_d = fcs_pkg::ST_INIT;
                end
            end
            fcs_pkg::ST_INIT: begin
                init_d = init_q + 8'h01;
                if (init_q == INIT_CYCLES) begin
                    state_d = fcs_pkg::ST_USER;
                end
            end
            fcs_pkg::ST_USER: begin
            end
            fcs_pkg::ST_JTAG: begin
                init_d = 8'h0;
                if (!s_jtag) begin
                    state_d = fcs_pkg::ST_DONE_WAIT;
                end
            end
        endcase
        if (state_q != fcs_pkg::ST_POR) begin
            if (s_jtag) begin
                state_d = fcs_pkg::ST_JTAG;
            end else if (!s_req) begin
                state_d = fcs_pkg::ST_RESET;
            end
        end
        stat_oe_d = state_d inside {fcs_pkg::ST_POR, fcs_pkg::ST_RESET};
        done_oe_d = state_d inside {fcs_pkg::ST_POR, fcs_pkg::ST_RESET,
            fcs_pkg::ST_RELEASE, fcs_pkg::ST_CONFIG, fcs_pkg::ST_JTAG};
        user_oe_d = state_d == fcs_pkg::ST_USER;
        pu_d = state_d != fcs_pkg::ST_USER;
        user_mode_d = state_d == fcs_pkg::ST_USER;
        chain_n_d = !(state_d inside {fcs_pkg::ST_INIT,
                                      fcs_pkg::ST_USER});
        cclk_oe_d = master && state_d == fcs_pkg::ST_CONFIG;
        fsel_n_d = !(master && state_d == fcs_pkg::ST_CONFIG);
        ado_oe_d = mode_q.scheme == fcs_pkg::SCH_SELF_DRIVEN_SERIAL &&
                   state_d == fcs_pkg::ST_CONFIG;
        if (state_d != fcs_pkg::ST_CONFIG) begin
            clk_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= fcs_pkg::ST_POR;
            mode_q <= '0;
            por_cnt_q <= 12'h0;
            div_q <= 8'h0;
            clk_q <= 1'b0;
            init_q <= 8'h0;
            sr_q <= 8'h0;
            nib_q <= 3'h0;
            op_q <= 8'h0;
            op_cnt_q <= 4'h0;
            ado_q <= 1'b0;
            bits_q <= 32'h0;
            chk_q <= 8'h0;
            stat_oe_q <= 1'b1;
            done_oe_q <= 1'b1;
            user_oe_q <= 1'b0;
            pu_q <= 1'b1;
            user_mode_q <= 1'b0;
            chain_n_q <= 1'b1;
            cclk_oe_q <= 1'b0;
            fsel_n_q <= 1'b1;
            ado_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            por_cnt_q <= por_cnt_d;
            div_q <= div_d;
            clk_q <= clk_d;
            init_q <= init_d;
            sr_q <= sr_d;
            nib_q <= nib_d;
            op_q <= op_d;
            op_cnt_q <= op_cnt_d;
            ado_q <= ado_d;
            bits_q <= bits_d;
            chk_q <= chk_d;
            stat_oe_q <= stat_oe_d;
            done_oe_q <= done_oe_d;
            user_oe_q <= user_oe_d;
            pu_q <= pu_d;
            user_mode_q <= user_mode_d;
            chain_n_q <= chain_n_d;
            cclk_oe_q <= cclk_oe_d;
            fsel_n_q <= fsel_n_d;
            ado_oe_q <= ado_oe_d;
        end
    end

    assign config_status_line_n_oe = stat_oe_q;
    assign load_complete_line_oe = done_oe_q;
    assign config_clock_o = clk_q;
    assign config_clock_oe = cclk_oe_q;
    assign serial_addr_data_out_o = ado_q;
    assign serial_addr_data_out_oe = ado_oe_q;
    assign serial_flash_select_n = fsel_n_q;
    assign chain_enable_out_n = chain_n_q;
    assign user_pin_oe = user_oe_q;
    assign weak_pullup_en = pu_q;
    assign user_mode = user_mode_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    por_hold_lines_a: assert property (
        state_q == fcs_pkg::ST_POR |-> stat_oe_q && done_oe_q && !user_oe_q)
        else $error("lines not held low during power-on reset");
    por_length_a: assert property (
        $past(state_q) == fcs_pkg::ST_POR && state_q != fcs_pkg::ST_POR
        |-> $past(por_cnt_q) == por_limit)
        else $error("power-on reset length wrong for straps");
    pins_tristate_a: assert property (
        state_q != fcs_pkg::ST_USER |-> !user_pin_oe && weak_pullup_en)
        else $error("user pins driven before user mode");
    reset_hold_a: assert property (
        state_q != fcs_pkg::ST_POR && !s_req && !s_jtag
        |=> state_q == fcs_pkg::ST_RESET && stat_oe_q)
        else $error("low request did not hold reset");
    status_release_a: assert property (
        state_q == fcs_pkg::ST_RESET && s_req && !s_jtag
        |=> !config_status_line_n_oe ##1 !config_status_line_n_oe)
        else $error("status line not released on request");
    config_enter_a: assert property (
        state_q == fcs_pkg::ST_RELEASE && s_stat && !s_ce_n && s_req
        && !s_jtag |=> state_q == fcs_pkg::ST_CONFIG)
        else $error("configuration stage not entered");
    word_latch_a: assert property (
        state_q == fcs_pkg::ST_CONFIG && !master && config_clock_rise && s_req
        && !s_jtag && !par |=> sr_q[0] == $past(s_data[0]))
        else $error("serial data bit not latched on clock");
    done_release_a: assert property (
        state_q == fcs_pkg::ST_CONFIG && bits_q >= len_q && s_req && !s_jtag
        |=> !load_complete_line_oe)
        else $error("done line not released after full image");
    init_after_done_a: assert property (
        $rose(state_q == fcs_pkg::ST_INIT) |-> $past(done_rise))
        else $error("initialization without done rising edge");
    run_expand_a: assert property (
        state_q == fcs_pkg::ST_CONFIG && tick && !op_busy && byte_rdy
        && ctrl_q.compress && word[7] && s_req && !s_jtag
        |=> bits_q == $past(bits_q) + {21'h0, $past({1'b0, word[6:0]})
                                       + 8'h01, 3'h0})
        else $error("compressed run length miscounted");
    parallel_pins_a: assert property (
        par |-> !serial_addr_data_out_oe)
        else $error("address pin driven in parallel scheme");
    jtag_priority_a: assert property (
        state_q != fcs_pkg::ST_POR && s_jtag |=> state_q == fcs_pkg::ST_JTAG)
        else $error("boundary-scan load did not take over");
    jtag_no_clock_a: assert property (
        state_q == fcs_pkg::ST_JTAG |-> !config_clock_oe)
        else $error("config clock driven during boundary-scan load");
    user_release_a: assert property (
        state_q == fcs_pkg::ST_INIT && init_q == INIT_CYCLES && s_req && !s_jtag
        |=> user_pin_oe && user_mode)
        else $error("user pins not released after initialization");
    chain_enable_a: assert property (
        state_q inside {fcs_pkg::ST_INIT, fcs_pkg::ST_USER}
        |-> !chain_enable_out_n)
        else $error("chain enable not asserted after configuration");

    reach_user_c: cover property (state_q == fcs_pkg::ST_USER);
    jtag_abort_c: cover property (
        state_q == fcs_pkg::ST_CONFIG ##1 state_q == fcs_pkg::ST_JTAG);
    run_byte_c: cover property (
        tick && byte_rdy && ctrl_q.compress && word[7]);
endmodule // fcs_top

/* design/fcs_consts.svh */
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Register byte offsets
`define FCS_OFF_CTRL 5'h00
`define FCS_OFF_LEN 5'h04
`define FCS_OFF_STAT 5'h08
`define FCS_OFF_COUNT 5'h0c
`define FCS_OFF_CHK 5'h10

// Field positions and reset values
`define FCS_CTRL_COMPRESS 0
`define FCS_CTRL_USER_CLK 1
`define FCS_CTRL_RESET 2'h0
`define FCS_LEN_RESET 32'h0000_1000
`define FCS_CMP_RUN_BIT 7

// Timing counts in core clock cycles (config clock half period in divider source ticks), then the read opcode and its bit count
`define FCS_POR_FAST_CYC 12'h100
`define FCS_POR_STD_CYC 12'h800
`define FCS_INIT_CYC 8'h40
`define FCS_CONFIG_CLOCK_HALF 8'h04
`define FCS_READ_OPCODE 8'h03
`define FCS_OPCODE_BITS 4'h8

`endif

/* design/fcs_pkg.sv */
package fcs_pkg;

    typedef enum logic [1:0] {
        SCH_SELF_DRIVEN_SERIAL,
        SCH_SLAVE_SERIAL,
        SCH_PARALLEL_FLASH_MASTER,
        SCH_SLAVE_PARALLEL_FAST
    } fcs_scheme_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_RELEASE,
        ST_CONFIG,
        ST_DONE_WAIT,
        ST_INIT,
        ST_USER,
        ST_JTAG
    } fcs_state_t;

    typedef struct packed {
        fcs_scheme_t scheme;
        logic por_slow;
    } fcs_mode_t;

    typedef struct packed {
        logic user_clk;
        logic compress;
    } fcs_ctrl_t;

endpackage

/* design/fcs_sync.sv */
`timescale 1ns/100ps
module fcs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [3*W-1:0] s_q;
    logic [3*W-1:0] s_d;

    // Two stages resync, third stage only for edge finding
    always_comb begin
        s_d = {s_q[2*W-1:0], d};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q[2*W-1:W];
    assign rise = s_q[2*W-1:W] & ~s_q[3*W-1:2*W];
endmodule // fcs_sync

/* tb/fcs_src_model.sv */
`timescale 1ns/100ps
module fcs_src_model (
    output logic cfg_clk,
    output logic cfg_dat
);
    initial begin
        cfg_clk = 1'b0;
        cfg_dat = 1'b0;
    end
    // Slave serial source, MSB first, clock still outside frames
    task automatic send_byte(input logic [7:0] b);
        // Keep edges off the core clock's sampling edge
        #5;
        for (int k = 7; k >= 0; k--) begin
            cfg_dat = b[k];
            #80 cfg_clk = 1'b1;
            #80 cfg_clk = 1'b0;
        end
        // Line let go: show the inverse of the last bit
        cfg_dat = ~b[0];
    endtask
endmodule // fcs_src_model

/* tb/fcs_top_tb_top.sv */
`timescale 1ns/100ps
`include "fcs_consts.svh"
module fcs_top_tb_top;
    logic core_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, v;
    logic wait_n, req_n = 1'b0, jtag = 1'b0, hold = 1'b1;
    logic ce_n = 1'b0, uclk = 1'b0, ck_o, ad_o;
    logic [2:0] pins = 3'h3;
    logic st_oe, dn_oe, ck_oe, sel_n, ad_oe, chain_n, pin_oe, pu, um;
    logic cclk, cdat;
    int num_errors = 0, n_tests = 0;
    int span = 0;
    always #10 core_clk = ~core_clk;
    // User clock source, edges fall between core clock rising edges
    always #40 uclk = ~uclk;
    fcs_src_model src (.cfg_clk(cclk), .cfg_dat(cdat));
    fcs_top #(.POR_FAST_CYCLES(12'h010), .POR_STD_CYCLES(12'h040),
        .INIT_CYCLES(8'h08)) uut (
        .core_clk(core_clk), .rst(rst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_readdata(rdat), .avs_waitrequest(wait_n),
        .scheme_select_pins(pins), .config_request_n(req_n),
        .chip_enable_in_n(ce_n), .jtag_config_req(jtag),
        .config_status_line_n_i(~st_oe), .config_status_line_n_o(),
        .config_status_line_n_oe(st_oe),
        .load_complete_line_i(~(dn_oe | hold)), .load_complete_line_o(),
        .load_complete_line_oe(dn_oe), .config_clock_i(cclk),
        .config_clock_o(ck_o), .config_clock_oe(ck_oe),
        .user_clock_source(uclk), .config_data_i({7'h00, cdat}),
        .serial_addr_data_out_i(1'b0), .serial_addr_data_out_o(ad_o),
        .serial_addr_data_out_oe(ad_oe), .serial_flash_select_n(sel_n),
        .chain_enable_out_n(chain_n), .user_pin_oe(pin_oe),
        .weak_pullup_en(pu), .user_mode(um));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int i;
        i = 0;
        @(posedge core_clk);
        addr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge core_clk);
            i++;
        end while (wait_n !== 1'b0 && i < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i >= 50) begin
            chk("waitrequest", 32'h0, 32'h1);
            end_of_test();
        end
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic wait_st(input logic [2:0] s);
        int i;
        i = 0;
        do begin
            bus(1'b0, `FCS_OFF_STAT, 32'h0, v);
            i++;
        end while (v[2:0] !== s && i < 300);
        chk("state", {29'h0, s}, {29'h0, v[2:0]});
        if (v[2:0] !== s) end_of_test();
    endtask
    // Address pin bits at the first 8 config clock rises, and the span
    // in core cycles from the first rise to the eighth
    task automatic grab_op(output logic [31:0] op, output int ns);
        int i;
        int n;
        int t0;
        logic p;
        i = 0;
        n = 0;
        t0 = 0;
        p = 1'b1;
        op = 32'h0;
        ns = 0;
        while (n < 8 && i < 400) begin
            @(posedge core_clk);
            i++;
            if (ck_o === 1'b1 && p === 1'b0) begin
                op = {op[30:0], ad_o};
                if (n == 0) t0 = i;
                n++;
                ns = i - t0;
            end
            p = ck_o;
        end
        if (n < 8) begin
            chk("config clock", 32'h8, n);
            end_of_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        chk("por lines", 32'h3, {30'h0, st_oe, dn_oe});
        chk("por pins", 32'h1, {30'h0, pin_oe, pu});
        rst <= 1'b0;
        repeat (24) @(posedge core_clk);
        rd_chk("stat por", `FCS_OFF_STAT, 32'h50);
        rd_chk("ctrl", `FCS_OFF_CTRL, 32'h0);
        rd_chk("len", `FCS_OFF_LEN, `FCS_LEN_RESET);
        bus(1'b1, 5'h14, 32'hffff_ffff, v);
        rd_chk("unmapped", 5'h14, 32'h0);
        wait_st(3'h1);
        chk("reset lines", 32'h5, {29'h0, st_oe, pin_oe, pu});
        $display("test reset done");
        bus(1'b1, `FCS_OFF_CTRL, 32'h1, v);
        bus(1'b1, `FCS_OFF_LEN, 32'd24, v);
        req_n <= 1'b1;
        wait_st(3'h3);
        chk("status oe", 32'h0, {31'h0, st_oe});
        src.send_byte(8'h81);
        src.send_byte(8'h3c);
        wait_st(3'h4);
        rd_chk("count", `FCS_OFF_COUNT, 32'd24);
        rd_chk("chk", `FCS_OFF_CHK, 32'hbd);
        chk("done oe", 32'h0, {31'h0, dn_oe});
        repeat (20) @(posedge core_clk);
        rd_chk("held", `FCS_OFF_STAT, 32'h54);
        hold <= 1'b0;
        wait_st(3'h5);
        chk("init", 32'h1, {30'h0, chain_n, pu});
        wait_st(3'h6);
        chk("user", 32'h6, {29'h0, pin_oe, um, pu});
        req_n <= 1'b0;
        wait_st(3'h1);
        chk("rereset", 32'h2, {30'h0, st_oe, pin_oe});
        $display("test slave load done");
        for (int s = 0; s < 2; s++) begin
            rst <= 1'b1;
            hold <= 1'b1;
            ce_n <= 1'b1;
            pins <= (s == 0) ? 3'h0 : 3'h4;
            repeat (5) @(posedge core_clk);
            rst <= 1'b0;
            wait_st(3'h1);
            chk("bus float", 32'h4, {29'h0, sel_n, ck_oe, ad_oe});
            bus(1'b1, `FCS_OFF_CTRL, (s == 0) ? 32'h0 : 32'h2, v);
            req_n <= 1'b1;
            wait_st(3'h2);
            ce_n <= 1'b0;
            grab_op(v, span);
            chk("opcode", (s == 0) ? `FCS_READ_OPCODE : 8'h00, v);
            chk("clock span", (s == 0) ? 32'd56 : 32'd224, span);
            wait_st(3'h3);
            chk("select", 32'h0, {31'h0, sel_n});
            chk("master clk", (s == 0) ? 32'h3 : 32'h2,
                {30'h0, ck_oe, ad_oe});
            if (s == 0) begin
                jtag <= 1'b1;
                wait_st(3'h7);
                chk("jtag clk", 32'h0, {31'h0, ck_oe});
                jtag <= 1'b0;
                wait_st(3'h4);
            end
            req_n <= 1'b0;
        end
        $display("test master done");
        end_of_test();
    end
endmodule // fcs_top_tb_top
